// file: verilog/ahss_pkg.sv
// shared constants and types of the automatic home search sequencer
// assumes one core clock; all users refer to names as ahss_pkg::name
package ahss_pkg;

  // detection source selected by a step's mode
  localparam logic [1:0] DET_NEAR = 2'h0;
  localparam logic [1:0] DET_HOME = 2'h1;
  localparam logic [1:0] DET_LIMIT = 2'h2;

  // step numbers
  localparam logic [1:0] STEP_FAST = 2'h0;
  localparam logic [1:0] STEP_SLOW = 2'h1;
  localparam logic [1:0] STEP_INDEX = 2'h2;
  localparam logic [1:0] STEP_OFFSET = 2'h3;

  // bit of the error status word set on an index input active at start
  localparam int INDEX_ERR_BIT = 6;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // deviation clear pulse width in cycles and decelerating stop length in pulses
  localparam int DCC_PULSE_CYCLES = 4;
  localparam logic [15:0] DECEL_PULSES = 16'h0004;

  // per-step mode setting
  typedef struct packed {
    logic enable;   // step is executed
    logic dir;      // 1 = plus direction
    logic [1:0] det_sel; // detection source
    logic dcc_en;   // pulse deviation clear on detection
    logic clr_en;   // clear position counters on detection
    logic timer_en; // wait out the inter-step timer afterwards
  } ahss_step_cfg_type;

  // sensor inputs after synchronisation
  typedef struct packed {
    logic near_home;
    logic home;
    logic index;
    logic plus_limit;
    logic minus_limit;
  } ahss_sense_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_BEGIN, ST_SEARCH, ST_ESCAPE, ST_DECEL,
    ST_OFFSET, ST_DCC, ST_WAIT, ST_NEXT
  } ahss_state_type;

endpackage : ahss_pkg

// file: verilog/ahss_pulse_gen.sv
// drive pulse generator: one pulse every period cycles while run is high
// assumes period is stable during a move; a period of 0 acts as 1
`timescale 1ns/1ns
module ahss_pulse_gen #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic pulse
);

  logic [W-1:0] count_r;
  logic pulse_r;
  wire logic wrap = (count_r + 1'b1 >= period);

  // period counter, cleared whenever the drive is halted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      pulse_r <= 1'b0;
    end else if (!run) begin
      count_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      count_r <= wrap ? '0 : count_r + 1'b1;
      pulse_r <= wrap;
    end
  end

  assign pulse = pulse_r;

endmodule : ahss_pulse_gen

// file: verilog/ahss_sequencer.sv
// automatic home search sequencer for one axis
// assumes asynchronous sensor pins, host mode settings stable while busy
//
// Notes on behaviour
// - steps run in order fast, slow, index, offset without host help
// - a disabled step is skipped and the next one starts at once
// - each step takes direction from its own mode, steps one and two also the detection source
// - steps one and four pulse at the drive speed setting
// - steps two and three pulse at the home search speed setting
// - step one detects near-home, home or limit input
// - step two detects home or limit input only
// - steps two and three may pulse deviation clear and clear counters
// - after a step an optional inter-step timer is waited out
// - near-home found in step one gives a decelerating stop
// - home found in step two stops pulses at once
// - home or limit searched fast, decelerate, then slow phase follows
// - slow phase first escapes opposite until input inactive, then searches
// - a limit as detection means the limit ahead in search direction
// - index active when step three starts sets error bit and ends search
// - step four outputs the programmed pulse count as a relative move
// - next step waits until the whole deviation clear pulse is out
// - step three drives at constant speed and stops on index active
`timescale 1ns/1ns
module ahss_sequencer #(
  parameter int W = 16,
  parameter int DCC_CYCLES = ahss_pkg::DCC_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire ahss_pkg::ahss_step_cfg_type [3:0] step_cfg,
  input wire logic [W-1:0] drive_speed_param,
  input wire logic [W-1:0] home_search_speed_param,
  input wire logic [W-1:0] drive_pulse_count,
  input wire logic [W-1:0] inter_step_wait,
  input wire logic near_home_input,
  input wire logic home_sensor_input,
  input wire logic encoder_index_input,
  input wire logic plus_limit_input,
  input wire logic minus_limit_input,
  output logic pulse_out,
  output logic dir_out,
  output logic busy,
  output logic deviation_clear_output,
  output logic position_clear,
  output logic [7:0] error_status_register
);

  ahss_pkg::ahss_sense_type sync1_r, sync2_r;
  ahss_pkg::ahss_state_type state_r, state_nxt;
  logic [1:0] step_r, step_nxt;
  logic [W-1:0] cnt_r, cnt_nxt, decel_r, decel_nxt;
  logic dir_r, dcc_r, pclr_r, pclr_nxt, err_nxt;
  logic [7:0] err_r;

  // limit lying ahead in the given direction
  function automatic logic limit_ahead(input logic dir,
                                       input ahss_pkg::ahss_sense_type s);
    limit_ahead = dir ? s.plus_limit : s.minus_limit;
  endfunction : limit_ahead
  // detection input of a step from its mode setting
  function automatic logic det_of(input logic [1:0] step,
                                  input ahss_pkg::ahss_step_cfg_type c,
                                  input ahss_pkg::ahss_sense_type s);
    if (step == ahss_pkg::STEP_INDEX)
      det_of = s.index;
    else if (c.det_sel == ahss_pkg::DET_LIMIT)
      det_of = limit_ahead(c.dir, s);
    else if (c.det_sel == ahss_pkg::DET_NEAR && step == ahss_pkg::STEP_FAST)
      det_of = s.near_home;
    else
      det_of = s.home;
  endfunction : det_of

  // two-flop synchroniser for all sensor pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {near_home_input, home_sensor_input, encoder_index_input,
                  plus_limit_input, minus_limit_input};
      sync2_r <= sync1_r;
    end
  end

  // current step decode
  wire ahss_pkg::ahss_step_cfg_type cur = step_cfg[step_r];
  wire logic det = det_of(step_r, cur, sync2_r);
  wire logic lim_ahead = limit_ahead(cur.dir, sync2_r);
  wire logic fast_step = (step_r == ahss_pkg::STEP_FAST) ||
                         (step_r == ahss_pkg::STEP_OFFSET);
  wire logic last_pulse = pulse_out && (cnt_r == {{(W-1){1'b0}}, 1'b1});
  wire logic decel_done = pulse_out && (cnt_r <= {{(W-1){1'b0}}, 1'b1});
  wire logic fast_limit = (step_r == ahss_pkg::STEP_FAST) &&
                          (cur.det_sel != ahss_pkg::DET_LIMIT) && lim_ahead;
  wire logic hit = (state_r == ahss_pkg::ST_SEARCH) && (det || fast_limit);
  wire ahss_pkg::ahss_state_type end_state = (cur.timer_en &&
    inter_step_wait != '0) ? ahss_pkg::ST_WAIT : ahss_pkg::ST_NEXT;

  // pulse drive: stop within the cycle of slow-step detection or last pulse
  wire logic moving = (state_r == ahss_pkg::ST_SEARCH) ||
                      (state_r == ahss_pkg::ST_ESCAPE) ||
                      (state_r == ahss_pkg::ST_DECEL) ||
                      (state_r == ahss_pkg::ST_OFFSET);
  wire logic slow_hit = hit && !fast_step;
  wire logic run = moving && !slow_hit && !last_pulse &&
                   !(state_r == ahss_pkg::ST_DECEL && decel_done);
  wire logic [W-1:0] period =
    (state_r == ahss_pkg::ST_DECEL) ? decel_r :
    fast_step ? drive_speed_param : home_search_speed_param;

  ahss_pulse_gen #(.W(W)) u_pulse (
    .core_clk(core_clk),
    .rst(rst),
    .run(run),
    .period(period),
    .pulse(pulse_out)
  );

  // sequence control
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    decel_nxt = decel_r;
    pclr_nxt = 1'b0;
    err_nxt = 1'b0;
    unique case (state_r)
      ahss_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = ahss_pkg::ST_BEGIN;
          step_nxt = ahss_pkg::STEP_FAST;
        end
      end
      ahss_pkg::ST_BEGIN: begin
        if (!cur.enable) begin
          state_nxt = ahss_pkg::ST_NEXT;
        end else if (step_r == ahss_pkg::STEP_FAST) begin
          state_nxt = (det || lim_ahead) ? end_state : ahss_pkg::ST_SEARCH;
        end else if (step_r == ahss_pkg::STEP_SLOW) begin
          state_nxt = det ? ahss_pkg::ST_ESCAPE : ahss_pkg::ST_SEARCH;
        end else if (step_r == ahss_pkg::STEP_INDEX) begin
          if (det) begin
            err_nxt = 1'b1;
            state_nxt = ahss_pkg::ST_IDLE;
          end else begin
            state_nxt = ahss_pkg::ST_SEARCH;
          end
        end else begin
          cnt_nxt = drive_pulse_count;
          state_nxt = (drive_pulse_count == '0) ? end_state :
                      ahss_pkg::ST_OFFSET;
        end
      end
      ahss_pkg::ST_SEARCH: begin
        if (hit && step_r == ahss_pkg::STEP_FAST) begin
          if (fast_limit) begin
            state_nxt = end_state;
          end else begin
            state_nxt = ahss_pkg::ST_DECEL;
            decel_nxt = drive_speed_param;
            cnt_nxt = W'(ahss_pkg::DECEL_PULSES);
          end
        end else if (hit) begin
          pclr_nxt = cur.clr_en;
          cnt_nxt = W'(DCC_CYCLES);
          state_nxt = cur.dcc_en ? ahss_pkg::ST_DCC : end_state;
        end
      end
      ahss_pkg::ST_ESCAPE: begin
        if (!det)
          state_nxt = ahss_pkg::ST_SEARCH;
      end
      ahss_pkg::ST_DECEL: begin
        if (decel_done) begin
          state_nxt = end_state;
        end else if (pulse_out) begin
          cnt_nxt = cnt_r - 1'b1;
          decel_nxt = decel_r[W-1] ? decel_r : {decel_r[W-2:0], 1'b0};
        end
      end
      ahss_pkg::ST_OFFSET: begin
        if (last_pulse)
          state_nxt = end_state;
        else if (pulse_out)
          cnt_nxt = cnt_r - 1'b1;
      end
      ahss_pkg::ST_DCC: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
          state_nxt = end_state;
          cnt_nxt = '0;
        end
      end
      ahss_pkg::ST_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= inter_step_wait) begin
          state_nxt = ahss_pkg::ST_NEXT;
          cnt_nxt = '0;
        end
      end
      ahss_pkg::ST_NEXT: begin
        cnt_nxt = '0;
        if (step_r == ahss_pkg::STEP_OFFSET) begin
          state_nxt = ahss_pkg::ST_IDLE;
        end else begin
          step_nxt = step_r + 2'h1;
          state_nxt = ahss_pkg::ST_BEGIN;
        end
      end
    endcase
    if (state_nxt == ahss_pkg::ST_WAIT && state_r != ahss_pkg::ST_WAIT)
      cnt_nxt = '0; // wait always counts from zero
  end

  // state registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ahss_pkg::ST_IDLE;
      step_r <= ahss_pkg::STEP_FAST;
      cnt_r <= '0;
      decel_r <= '0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      decel_r <= decel_nxt;
    end
  end

  // outputs from flops; error bit holds until the next start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_r <= 1'b0;
      dcc_r <= 1'b0;
      pclr_r <= 1'b0;
      err_r <= ahss_pkg::ERR_RESET;
    end else begin
      dir_r <= (state_nxt == ahss_pkg::ST_ESCAPE) ? ~cur.dir : cur.dir;
      dcc_r <= (state_nxt == ahss_pkg::ST_DCC);
      pclr_r <= pclr_nxt;
      if (err_nxt)
        err_r[ahss_pkg::INDEX_ERR_BIT] <= 1'b1;
      else if (start && state_r == ahss_pkg::ST_IDLE)
        err_r <= ahss_pkg::ERR_RESET;
    end
  end

  assign dir_out = dir_r;
  assign busy = (state_r != ahss_pkg::ST_IDLE);
  assign deviation_clear_output = dcc_r;
  assign position_clear = pclr_r;
  assign error_status_register = err_r;
  // checks
  sequence seq_dcc_high;
    deviation_clear_output [*4];
  endsequence
  a_busy_while_run: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ahss_pkg::ST_WAIT || moving) |-> busy)
    else $error("busy low while sequence active");
  a_skip_disabled: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ahss_pkg::ST_BEGIN && !cur.enable) |=>
    state_r == ahss_pkg::ST_NEXT ##1 (step_r == $past(step_r, 2) + 2'h1 ||
    state_r == ahss_pkg::ST_IDLE))
    else $error("disabled step not skipped");
  a_step_order: assert property (@(posedge core_clk) disable iff (rst)
    (busy && $past(busy) && step_r != $past(step_r)) |->
    step_r == $past(step_r) + 2'h1)
    else $error("step order broken");
  a_fast_speed: assert property (@(posedge core_clk) disable iff (rst)
    (run && fast_step && state_r != ahss_pkg::ST_DECEL) |->
    period == drive_speed_param)
    else $error("fast step not at drive speed");
  a_slow_speed: assert property (@(posedge core_clk) disable iff (rst)
    (run && !fast_step) |-> period == home_search_speed_param)
    else $error("slow step not at home search speed");
  a_slow_instant: assert property (@(posedge core_clk) disable iff (rst)
    slow_hit |-> !run ##1 !pulse_out)
    else $error("pulse after slow detection");
  a_fast_decel: assert property (@(posedge core_clk) disable iff (rst)
    (hit && step_r == ahss_pkg::STEP_FAST && !fast_limit) |=>
    state_r == ahss_pkg::ST_DECEL)
    else $error("no decelerating stop in fast search");
  a_index_error: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ahss_pkg::ST_BEGIN && cur.enable &&
     step_r == ahss_pkg::STEP_INDEX && det) |=>
    error_status_register[ahss_pkg::INDEX_ERR_BIT] && !busy)
    else $error("index active at start not flagged");
  a_dcc_width: assert property (@(posedge core_clk) disable iff (rst)
    $rose(deviation_clear_output) |->
    seq_dcc_high ##1 !deviation_clear_output)
    else $error("deviation clear pulse width wrong");
  a_escape_dir: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ahss_pkg::ST_ESCAPE && $past(state_r) ==
     ahss_pkg::ST_ESCAPE) |-> dir_out == ~cur.dir)
    else $error("escape not opposite to search");
endmodule : ahss_sequencer

// file: test/ahss_axis_model.sv
// axis model: motor driver, sensor strip along the axis and position counters
// assumes pulse and direction from the sequencer on the same core clock
`timescale 1ns/1ns
module ahss_axis_model #(
  parameter int NEAR_LO = 40,
  parameter int NEAR_HI = 60,
  parameter int HOME_LO = 50,
  parameter int HOME_HI = 55,
  parameter int IDX_LO = 70,
  parameter int IDX_HI = 71,
  parameter int PLUS_LIM = 200,
  parameter int MINUS_LIM = -200
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic position_clear,
  input wire logic preset,
  input wire logic signed [31:0] preset_pos,
  output logic near_home_input,
  output logic home_sensor_input,
  output logic encoder_index_input,
  output logic plus_limit_input,
  output logic minus_limit_input,
  output logic signed [31:0] pos,
  output logic signed [31:0] logical_pos
);
  // one step of travel per drive pulse; the counter clear leaves the
  // mechanical position alone, as on a real axis
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pos <= '0;
      logical_pos <= '0;
    end else if (preset) begin
      pos <= preset_pos;
      logical_pos <= preset_pos;
    end else begin
      if (pulse_out)
        pos <= dir_out ? pos + 1 : pos - 1;
      if (position_clear)
        logical_pos <= '0;
      else if (pulse_out)
        logical_pos <= dir_out ? logical_pos + 1 : logical_pos - 1;
    end
  end

  // sensors are level regions along the axis
  assign near_home_input = (pos >= NEAR_LO) && (pos <= NEAR_HI);
  assign home_sensor_input = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign encoder_index_input = (pos >= IDX_LO) && (pos <= IDX_HI);
  assign plus_limit_input = (pos >= PLUS_LIM);
  assign minus_limit_input = (pos <= MINUS_LIM);
endmodule : ahss_axis_model

// file: test/automatic_home_search_sequencer_tb.sv
// self-checking bench of the home search sequencer with an axis model
// assumes the design and package under verilog/ are compiled first
`timescale 1ns/1ns
module automatic_home_search_sequencer_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic preset = 1'b0;
  logic signed [31:0] preset_pos = '0;
  ahss_pkg::ahss_step_cfg_type [3:0] step_cfg = '0;
  logic [15:0] drv_per = 16'h0002, home_per = 16'h0006;
  logic [15:0] off_cnt = 16'h0001, wt = 16'h0000;
  logic near, home, idx, plim, mlim, pulse_out, dir_out, busy, dcc, pclr;
  logic [7:0] err_reg;
  logic signed [31:0] pos, lpos;
  int err_total = 0, n_compared = 0;
  int n_busy, n_pulse, n_minus, n_dcc, n_dcc_busy, n_clr, gap, gmin, gmax;

  ahss_sequencer ahss_sequencer_inst (.core_clk(core_clk), .rst(rst),
    .start(start), .step_cfg(step_cfg), .drive_speed_param(drv_per),
    .home_search_speed_param(home_per), .drive_pulse_count(off_cnt),
    .inter_step_wait(wt), .near_home_input(near), .home_sensor_input(home),
    .encoder_index_input(idx), .plus_limit_input(plim),
    .minus_limit_input(mlim), .pulse_out(pulse_out), .dir_out(dir_out),
    .busy(busy), .deviation_clear_output(dcc), .position_clear(pclr),
    .error_status_register(err_reg));

  ahss_axis_model ahss_axis_model_inst (.core_clk(core_clk), .rst(rst),
    .pulse_out(pulse_out), .dir_out(dir_out), .position_clear(pclr),
    .preset(preset), .preset_pos(preset_pos), .near_home_input(near),
    .home_sensor_input(home), .encoder_index_input(idx),
    .plus_limit_input(plim), .minus_limit_input(mlim), .pos(pos),
    .logical_pos(lpos));

  // clock of 50 ns period
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // monitor counts busy cycles, pulses, pulse gaps and clear pulses
  always @(posedge core_clk) begin
    gap++;
    if (busy === 1'b1) n_busy++;
    if (dcc === 1'b1) n_dcc++;
    if (dcc === 1'b1 && busy === 1'b1) n_dcc_busy++;
    if (pclr === 1'b1) n_clr++;
    if (pulse_out === 1'b1) begin
      if (n_pulse > 0 && gap < gmin) gmin = gap;
      if (n_pulse > 0 && gap > gmax) gmax = gap;
      if (dir_out === 1'b0) n_minus++;
      n_pulse++;
      gap = 0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  function automatic ahss_pkg::ahss_step_cfg_type sc(input logic e, d,
      input logic [1:0] s, input logic dc, cl, tm);
    return '{enable: e, dir: d, det_sel: s, dcc_en: dc, clr_en: cl,
             timer_en: tm};
  endfunction : sc

  // places the axis, starts one sequence and waits for busy to drop
  task automatic run_seq(input ahss_pkg::ahss_step_cfg_type [3:0] c,
      input logic signed [31:0] p0);
    int k;
    @(posedge core_clk);
    step_cfg <= c;
    preset <= 1'b1;
    preset_pos <= p0;
    @(posedge core_clk);
    preset <= 1'b0;
    repeat (3) @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(negedge core_clk);
    {n_busy, n_pulse, n_minus, n_dcc, n_dcc_busy, n_clr} = '0;
    {gap, gmax, gmin} = {32'd0, 32'd0, 32'd999};
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 5000) check("busy drop", 32'h0, 32'h1);
    repeat (3) @(posedge core_clk);
  endtask : run_seq

  // offset step alone at drive speed, then with the inter-step wait
  task automatic t_offset;
    int b0;
    drv_per <= 16'h0003;
    off_cnt <= 16'h0005;
    run_seq({sc(1, 1, 0, 0, 0, 0), 21'h0}, 0);
    check("offset pos", pos, 32'd5);
    check("fast gap", {gmin[15:0], gmax[15:0]}, 32'h00030003);
    b0 = n_busy;
    wt <= 16'h0014;
    run_seq({sc(1, 1, 0, 0, 0, 1), 21'h0}, 0);
    check("wait span", 32'(n_busy - b0), 32'd20);
    wt <= 16'h0000;
  endtask : t_offset

  // every step disabled gives a short busy and no motion
  task automatic t_skip;
    run_seq('0, 0);
    check("skip pulses", 32'(n_pulse), 32'd0);
    check("skip busy", 32'(n_busy > 0 && n_busy <= 8), 32'h1);
  endtask : t_skip

  // all four steps: near, home, index, offset
  task automatic t_full;
    drv_per <= 16'h0002;
    off_cnt <= 16'h0005;
    run_seq({sc(1, 1, 0, 0, 0, 0), sc(1, 1, 1, 1, 1, 0),
             sc(1, 1, 1, 1, 1, 0), sc(1, 1, 0, 0, 0, 0)}, 0);
    check("full pos", pos, 32'd75);
    check("full logical", lpos, 32'd5);
    check("full dcc", 32'(n_dcc), 32'd8);
    check("full clears", 32'(n_clr), 32'd2);
  endtask : t_full

  // index step alone: slow constant speed, stops on the index edge
  task automatic t_index;
    run_seq({7'h0, sc(1, 1, 0, 0, 0, 0), 14'h0}, 60);
    check("index pos", pos, 32'd70);
    check("slow gap", {gmin[15:0], gmax[15:0]}, 32'h00060006);
    run_seq({sc(1, 1, 0, 0, 0, 0), sc(1, 1, 0, 0, 0, 0), 14'h0}, 70);
    check("index err", err_reg, 8'h40);
    check("index err moves", 32'(n_pulse), 32'd0);
    run_seq({sc(1, 1, 0, 0, 0, 0), 21'h0}, 0);
    check("err cleared", err_reg, 8'h00);
  endtask : t_index

  // home search from inside the home region escapes first
  task automatic t_escape;
    run_seq({14'h0, sc(1, 1, 1, 1, 0, 0), 7'h0}, 52);
    check("escape pos", pos, 32'd50);
    check("escape back", 32'(n_minus > 0), 32'h1);
    check("dcc in busy", 32'(n_dcc_busy), 32'd4);
  endtask : t_escape

  // fast search: decelerating stop on near-home, limit ahead used
  task automatic t_fast;
    run_seq({21'h0, sc(1, 1, 0, 0, 0, 0)}, 0);
    check("decel pos", 32'(pos >= 44 && pos <= 48), 32'h1);
    run_seq({21'h0, sc(1, 0, 2, 0, 0, 0)}, -190);
    check("limit pos", 32'(pos <= -200 && pos >= -210), 32'h1);
  endtask : t_fast

  // watchdog against a hung sequence
  initial begin
    #(60000 * 50);
    err_total++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_offset();
    t_skip();
    t_full();
    t_index();
    t_escape();
    t_fast();
    test_done();
  end
endmodule : automatic_home_search_sequencer_tb
